// ==== core/otdoc_cfg.sv ====
// Purpose: serial-loaded output type, analog delay and oscillator config
// Assumes: serial pins synchronous to clk_sys, data shifted msb first
// Notes:   decoded outputs follow the stored words by one clock
`timescale 1ns/1ns
`include "otdoc_consts.svh"

// Functional notes
// - four-bit type: 0 off, 1 LVDS, 2-5 LVPECL, 6-14 LVCMOS.
// - five-bit analog delay, codes 0-23, 25 ps per step.
// - programmed delay applies only when that output's select bit is set.
// - pair delay block powered down when neither output selects it.
// - engaged delay block adds a fixed 500 ps offset.
// - lower output delay in bits 9:5, higher output in bits 15:11.
// - oscillator output drives only with non-off type and enable bit 22.
// - source select 0 bypasses divider, 1 routes through it.
// - divide code 0 gives 8, codes 1 and 2 give 2, others own value.
// - divide by one only through the bypass path.
// - VCO path select 0 direct, 1 through the VCO divider.
// - VCO prescale value sets the divide when the divider is selected.
module otdoc_cfg (
   input  wire logic                           clk_sys,
   input  wire logic                           reset,
   input  wire logic                           serClk,
   input  wire logic                           serData,
   input  wire logic                           serLatchEn,
   input  wire logic [`OTDOC_NUM_CHAN-1:0]     chanDelaySel,
   output otdoc_pkg::otdoc_kind_e              chanKind [`OTDOC_NUM_CHAN],
   output logic [`OTDOC_NUM_CHAN-1:0]          chanBufOn,
   output logic [`OTDOC_NUM_CHAN-1:0]          chanDelayOn,
   output logic [`OTDOC_NUM_CHAN-1:0][`OTDOC_PS_W-1:0] chanDelayPs,
   output logic [`OTDOC_NUM_PAIR-1:0]          pairDelayPowered,
   output logic                                oscBufDrive,
   output otdoc_pkg::otdoc_kind_e              oscBufKind,
   output logic [`OTDOC_RATIO_W-1:0]           oscRatio,
   output logic                                oscInPowerdown,
   output logic                                vcoPathDivided,
   output logic [`OTDOC_RATIO_W-1:0]           vcoRatio,
   output logic                                feedbackMuxOn
);
   import otdoc_pkg::*;

   logic [`OTDOC_WORD_W-1:0] shift_reg, shift_next;
   logic                     serClk_reg, serClk_next;
   logic                     serLatch_reg, serLatch_next;
   logic [`OTDOC_WORD_W-1:0] group_reg [`OTDOC_NUM_PAIR];
   logic [`OTDOC_WORD_W-1:0] group_next [`OTDOC_NUM_PAIR];
   logic [`OTDOC_WORD_W-1:0] oscCtrl_reg, oscCtrl_next;
   logic                     latchEdge;
   logic [`OTDOC_ADDR_W-1:0] wrAddr;

   otdoc_kind_e                          chanKind_next [`OTDOC_NUM_CHAN];
   logic [`OTDOC_NUM_CHAN-1:0]           chanBufOn_next;
   logic [`OTDOC_NUM_CHAN-1:0][`OTDOC_PS_W-1:0] chanDelayPs_next;
   logic [`OTDOC_NUM_PAIR-1:0]           pairPowered_next;
   otdoc_kind_e                          oscKind_next;
   logic                                 oscDrive_next;
   logic [`OTDOC_RATIO_W-1:0]            oscRatio_next;
   logic [`OTDOC_RATIO_W-1:0]            vcoRatio_next;

   function automatic otdoc_kind_e kindOf(input logic [3:0] code);
      if (code == `OTDOC_TYPE_OFF || code > `OTDOC_TYPE_CMOS_MAX) begin
         kindOf = OTDOC_KIND_OFF;
      end else if (code == `OTDOC_TYPE_LVDS) begin
         kindOf = OTDOC_KIND_LVDS;
      end else if (code <= `OTDOC_TYPE_PECL_MAX) begin
         kindOf = OTDOC_KIND_LVPECL;
      end else begin
         kindOf = OTDOC_KIND_LVCMOS;
      end
   endfunction

   function automatic logic [3:0] ratioOf(input logic [2:0] code);
      if (code == 3'h0) begin
         ratioOf = `OTDOC_RATIO_CODE0;
      end else if (code == 3'h1) begin
         ratioOf = `OTDOC_RATIO_CODE1;
      end else begin
         ratioOf = {1'b0, code};
      end
   endfunction

   // serial shift and latch into the addressed word
   always_comb begin
      serClk_next   = serClk;
      serLatch_next = serLatchEn;
      latchEdge     = serLatchEn & ~serLatch_reg;
      wrAddr        = shift_reg[`OTDOC_ADDR_W-1:0];
      shift_next    = shift_reg;
      if (serClk && !serClk_reg) begin
         shift_next = {shift_reg[`OTDOC_WORD_W-2:0], serData};
      end
      group_next   = group_reg;
      oscCtrl_next = oscCtrl_reg;
      if (latchEdge) begin
         unique case (wrAddr)
            `OTDOC_ADDR_GROUP_A: group_next[0] = shift_reg;
            `OTDOC_ADDR_GROUP_B: group_next[1] = shift_reg;
            `OTDOC_ADDR_GROUP_C: group_next[2] = shift_reg;
            `OTDOC_ADDR_OSC_CTRL: oscCtrl_next = shift_reg;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         shift_reg    <= `OTDOC_RESET_WORD;
         serClk_reg   <= 1'b0;
         serLatch_reg <= 1'b0;
         group_reg    <= '{default: `OTDOC_RESET_WORD};
         oscCtrl_reg  <= `OTDOC_RESET_WORD;
      end else begin
         shift_reg    <= shift_next;
         serClk_reg   <= serClk_next;
         serLatch_reg <= serLatch_next;
         group_reg    <= group_next;
         oscCtrl_reg  <= oscCtrl_next;
      end
   end

   // per-channel type and delay decode
   for (genvar i = 0; i < `OTDOC_NUM_CHAN; i++) begin : g_chan
      localparam int TL = (i % 2 == 1) ? `OTDOC_TYPE_LSB_ODD :
                          (i == 4) ? `OTDOC_TYPE_LSB_CH4 :
                          `OTDOC_TYPE_LSB_EVEN;
      localparam int DL = (i % 2 == 1) ? `OTDOC_ADLY_LSB_ODD :
                          `OTDOC_ADLY_LSB_EVEN;
      logic [`OTDOC_TYPE_W-1:0] typeCode;
      logic [`OTDOC_ADLY_W-1:0] dlyCode;
      assign typeCode = group_reg[i/2][TL +: `OTDOC_TYPE_W];
      assign dlyCode = (group_reg[i/2][DL +: `OTDOC_ADLY_W] > `OTDOC_ADLY_MAX)
                       ? `OTDOC_ADLY_MAX : group_reg[i/2][DL +: `OTDOC_ADLY_W];
      assign chanKind_next[i]  = kindOf(typeCode);
      assign chanBufOn_next[i] = (kindOf(typeCode) != OTDOC_KIND_OFF);
      assign chanDelayPs_next[i] = chanDelaySel[i]
         ? `OTDOC_ADLY_FIXED_PS + `OTDOC_PS_W'(dlyCode) * `OTDOC_ADLY_STEP_PS
         : '0;
   end

   for (genvar p = 0; p < `OTDOC_NUM_PAIR; p++) begin : g_pair
      assign pairPowered_next[p] = chanDelaySel[2*p] | chanDelaySel[2*p+1];
   end

   always_comb begin
      oscKind_next  = kindOf(oscCtrl_reg[`OTDOC_OSC_TYPE_LSB +: 4]);
      oscDrive_next = (oscKind_next != OTDOC_KIND_OFF) &&
                      oscCtrl_reg[`OTDOC_OSC_EN_BIT];
      oscRatio_next = oscCtrl_reg[`OTDOC_OSC_MUX_BIT]
         ? ratioOf(oscCtrl_reg[`OTDOC_OSC_DIV_LSB +: `OTDOC_DIV_W])
         : `OTDOC_RATIO_BYPASS;
      vcoRatio_next = oscCtrl_reg[`OTDOC_VCO_PATH_SELECT_BIT]
         ? ratioOf(oscCtrl_reg[`OTDOC_VCO_PRESCALE_VALUE_LSB +: `OTDOC_DIV_W])
         : `OTDOC_RATIO_BYPASS;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         chanKind         <= '{default: OTDOC_KIND_OFF};
         chanBufOn        <= '0;
         chanDelayOn      <= '0;
         chanDelayPs      <= '0;
         pairDelayPowered <= '0;
         oscBufDrive      <= 1'b0;
         oscBufKind       <= OTDOC_KIND_OFF;
         oscRatio         <= `OTDOC_RATIO_BYPASS;
         oscInPowerdown   <= 1'b0;
         vcoPathDivided   <= 1'b0;
         vcoRatio         <= `OTDOC_RATIO_BYPASS;
         feedbackMuxOn    <= 1'b0;
      end else begin
         chanKind         <= chanKind_next;
         chanBufOn        <= chanBufOn_next;
         chanDelayOn      <= chanDelaySel;
         chanDelayPs      <= chanDelayPs_next;
         pairDelayPowered <= pairPowered_next;
         oscBufDrive      <= oscDrive_next;
         oscBufKind       <= oscKind_next;
         oscRatio         <= oscRatio_next;
         oscInPowerdown   <= oscCtrl_reg[`OTDOC_OSC_IN_PD_BIT];
         vcoPathDivided   <= oscCtrl_reg[`OTDOC_VCO_PATH_SELECT_BIT];
         vcoRatio         <= vcoRatio_next;
         feedbackMuxOn    <= oscCtrl_reg[`OTDOC_FB_MUX_BIT];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_type_lvds;
      group_reg[0][27:24] == 4'h1 |=> chanKind[1] == OTDOC_KIND_LVDS;
   endproperty
   a_type_lvds: assert property (p_type_lvds)
      else $error("type code 1 did not give lvds");
   property p_type_off;
      group_reg[2][19:16] == 4'h0 |=> !chanBufOn[4];
   endproperty
   a_type_off: assert property (p_type_off)
      else $error("type code 0 left buffer on");
   property p_delay_max;
      chanDelaySel[0] && group_reg[0][9:5] == 5'h17
         |=> chanDelayPs[0] == 11'h433;
   endproperty
   a_delay_max: assert property (p_delay_max)
      else $error("code 23 delay wrong");
   property p_delay_gate;
      !chanDelaySel[2] |=> chanDelayPs[2] == 11'h000 && !chanDelayOn[2];
   endproperty
   a_delay_gate: assert property (p_delay_gate)
      else $error("delay applied without select");
   property p_pair_pd;
      chanDelaySel[5:4] == 2'b00 ##1 chanDelaySel[5:4] == 2'b00
         |-> !pairDelayPowered[2] ##1 !pairDelayPowered[2];
   endproperty
   a_pair_pd: assert property (p_pair_pd)
      else $error("pair block powered with no select");
   property p_fixed_offset;
      chanDelaySel[3] && group_reg[1][15:11] == 5'h00
         |=> chanDelayPs[3] == 11'h1f4;
   endproperty
   a_fixed_offset: assert property (p_fixed_offset)
      else $error("fixed offset missing");
   property p_high_field;
      chanDelaySel[1] && group_reg[0][15:11] == 5'h01
         |=> chanDelayPs[1] == 11'h20d;
   endproperty
   a_high_field: assert property (p_high_field)
      else $error("higher output delay field misplaced");
   property p_osc_drive;
      oscBufDrive |-> $past(oscCtrl_reg[22]) &&
                      $past(oscCtrl_reg[27:24]) != 4'h0;
   endproperty
   a_osc_drive: assert property (p_osc_drive)
      else $error("oscillator output driven without both conditions");
   property p_bypass;
      !oscCtrl_reg[20] |=> oscRatio == 4'h1;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass did not give ratio one");
   property p_div_code0;
      oscCtrl_reg[20] && oscCtrl_reg[18:16] == 3'h0 |=> oscRatio == 4'h8;
   endproperty
   a_div_code0: assert property (p_div_code0)
      else $error("divide code 0 not eight");
   property p_div_not_one;
      oscCtrl_reg[20] |=> oscRatio != 4'h1;
   endproperty
   a_div_not_one: assert property (p_div_not_one)
      else $error("divided path gave ratio one");
   property p_vco_prescale_value;
      oscCtrl_reg[12] && oscCtrl_reg[10:8] == 3'h5
         |=> vcoPathDivided && vcoRatio == 4'h5;
   endproperty
   a_vco_prescale_value: assert property (p_vco_prescale_value)
      else $error("vco divider path wrong");
   property p_vco_direct;
      !oscCtrl_reg[12] |=> vcoRatio == 4'h1 && !vcoPathDivided;
   endproperty
   a_vco_direct: assert property (p_vco_direct)
      else $error("direct vco path wrong");

   c_osc_on: cover property (oscBufDrive && oscRatio == 4'h8);
   c_pair_on: cover property (pairDelayPowered[0] ##1 !pairDelayPowered[0]);
   c_vco_prescale_value: cover property (vcoPathDivided && vcoRatio == 4'h7);
   c_cmos: cover property (chanKind[5] == OTDOC_KIND_LVCMOS);
endmodule

// ==== core/otdoc_consts.svh ====
// Purpose: constants for the output type, delay and oscillator decode
// Assumes: 32-bit serial words, register address in the low five bits
// Notes:   field positions are bit numbers within the stored word
`ifndef OTDOC_CONSTS_SVH
`define OTDOC_CONSTS_SVH

`define OTDOC_WORD_W         32
`define OTDOC_ADDR_W         5
`define OTDOC_ADDR_GROUP_A   5'h06
`define OTDOC_ADDR_GROUP_B   5'h07
`define OTDOC_ADDR_GROUP_C   5'h08
`define OTDOC_ADDR_OSC_CTRL  5'h0a
`define OTDOC_RESET_WORD     32'h0000_0000

`define OTDOC_NUM_CHAN       6
`define OTDOC_NUM_PAIR       3
`define OTDOC_TYPE_W         4
`define OTDOC_TYPE_LSB_EVEN  20
`define OTDOC_TYPE_LSB_ODD   24
`define OTDOC_TYPE_LSB_CH4   16
`define OTDOC_TYPE_OFF       4'h0
`define OTDOC_TYPE_LVDS      4'h1
`define OTDOC_TYPE_PECL_MAX  4'h5
`define OTDOC_TYPE_CMOS_MAX  4'he

`define OTDOC_ADLY_W         5
`define OTDOC_ADLY_LSB_EVEN  5
`define OTDOC_ADLY_LSB_ODD   11
`define OTDOC_ADLY_MAX       5'h17
`define OTDOC_PS_W           11
`define OTDOC_ADLY_STEP_PS   11'h019
`define OTDOC_ADLY_FIXED_PS  11'h1f4

`define OTDOC_OSC_TYPE_LSB   24
`define OTDOC_OSC_EN_BIT     22
`define OTDOC_OSC_MUX_BIT    20
`define OTDOC_OSC_IN_PD_BIT  19
`define OTDOC_OSC_DIV_LSB    16
`define OTDOC_VCO_PATH_SELECT_BIT    12
`define OTDOC_FB_MUX_BIT     11
`define OTDOC_VCO_PRESCALE_VALUE_LSB    8
`define OTDOC_DIV_W          3
`define OTDOC_RATIO_W        4
`define OTDOC_RATIO_BYPASS   4'h1
`define OTDOC_RATIO_CODE0    4'h8
`define OTDOC_RATIO_CODE1    4'h2

`endif

// ==== core/otdoc_pkg.sv ====
// Purpose: types for the output type, delay and oscillator decode
// Assumes: nothing beyond the constants header
// Notes:   buffer kinds only; swing and polarity stay in the raw code
package otdoc_pkg;
   typedef enum logic [1:0] {
      OTDOC_KIND_OFF    = 2'b00,
      OTDOC_KIND_LVDS   = 2'b01,
      OTDOC_KIND_LVPECL = 2'b10,
      OTDOC_KIND_LVCMOS = 2'b11
   } otdoc_kind_e;
endpackage

// ==== tb/otdoc_cfg_tb_top.sv ====
// Purpose: self-checking bench for the output type, delay and osc decode
// Assumes: serial words shifted msb first, outputs two edges after latch
// Notes:   expectations come from shadow copies of the stored words
`timescale 1ns/1ns
`include "otdoc_consts.svh"

`define OTDOC_CHK(nm, ex, got) \
   begin checksDone++; if ((got) !== (ex)) begin nMismatch++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end

module otdoc_cfg_tb_top;
   import otdoc_pkg::*;
   logic                                clk_sys;
   logic                                reset;
   logic                                serClk;
   logic                                serData;
   logic                                serLatchEn;
   logic [`OTDOC_NUM_CHAN-1:0]          chanDelaySel;
   otdoc_kind_e                         chanKind [`OTDOC_NUM_CHAN];
   logic [`OTDOC_NUM_CHAN-1:0]          chanBufOn;
   logic [`OTDOC_NUM_CHAN-1:0]          chanDelayOn;
   logic [`OTDOC_NUM_CHAN-1:0][`OTDOC_PS_W-1:0] chanDelayPs;
   logic [`OTDOC_NUM_PAIR-1:0]          pairDelayPowered;
   logic                                oscBufDrive;
   otdoc_kind_e                         oscBufKind;
   logic [`OTDOC_RATIO_W-1:0]           oscRatio;
   logic                                oscInPowerdown;
   logic                                vcoPathDivided;
   logic [`OTDOC_RATIO_W-1:0]           vcoRatio;
   logic                                feedbackMuxOn;
   logic [31:0]                         grpWord [3];
   logic [31:0]                         oscWord;
   logic [31:0]                         lfsrState;
   logic [4:0]                          addrTab [8];
   int                                  nMismatch;
   int                                  checksDone;
   int                                  cycleCount;

   otdoc_cfg dut_u (
      .clk_sys          (clk_sys),
      .reset            (reset),
      .serClk           (serClk),
      .serData          (serData),
      .serLatchEn       (serLatchEn),
      .chanDelaySel     (chanDelaySel),
      .chanKind         (chanKind),
      .chanBufOn        (chanBufOn),
      .chanDelayOn      (chanDelayOn),
      .chanDelayPs      (chanDelayPs),
      .pairDelayPowered (pairDelayPowered),
      .oscBufDrive      (oscBufDrive),
      .oscBufKind       (oscBufKind),
      .oscRatio         (oscRatio),
      .oscInPowerdown   (oscInPowerdown),
      .vcoPathDivided   (vcoPathDivided),
      .vcoRatio         (vcoRatio),
      .feedbackMuxOn    (feedbackMuxOn)
   );

   always #50 clk_sys = ~clk_sys;

   function automatic otdoc_kind_e kind_of(logic [3:0] c);
      if (c == 4'h0 || c == 4'hf) return OTDOC_KIND_OFF;
      if (c == 4'h1) return OTDOC_KIND_LVDS;
      if (c <= 4'h5) return OTDOC_KIND_LVPECL;
      return OTDOC_KIND_LVCMOS;
   endfunction

   function automatic logic [3:0] ratio_of(logic [2:0] c);
      if (c == 3'h0) return 4'h8;
      if (c <= 3'h2) return 4'h2;
      return {1'b0, c};
   endfunction

   function automatic logic [10:0] dly_of(logic [4:0] c, logic s);
      logic [4:0] k;
      k = (c > 5'h17) ? 5'h17 : c;
      return s ? 11'h1f4 + 11'(k) * 11'h019 : 11'h000;
   endfunction

   function automatic logic [31:0] lfsr_next(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check_all();
      logic [31:0] w;
      logic [3:0]  t;
      logic [4:0]  d;
      otdoc_kind_e k;
      logic        on;
      logic [10:0] ps;
      logic [3:0]  r;
      for (int ch = 0; ch < `OTDOC_NUM_CHAN; ch++) begin
         w = grpWord[ch / 2];
         t = ch[0] ? w[27:24] : ((ch == 4) ? w[19:16] : w[23:20]);
         d = ch[0] ? w[15:11] : w[9:5];
         k = kind_of(t);
         on = (k != OTDOC_KIND_OFF);
         ps = dly_of(d, chanDelaySel[ch]);
         `OTDOC_CHK("chanKind", k, chanKind[ch])
         `OTDOC_CHK("chanBufOn", on, chanBufOn[ch])
         `OTDOC_CHK("chanDelayOn", chanDelaySel[ch], chanDelayOn[ch])
         `OTDOC_CHK("chanDelayPs", ps, chanDelayPs[ch])
      end
      for (int p = 0; p < `OTDOC_NUM_PAIR; p++) begin
         on = |chanDelaySel[2*p+:2];
         `OTDOC_CHK("pairPowered", on, pairDelayPowered[p])
      end
      w = oscWord;
      k = kind_of(w[27:24]);
      on = w[22] && (k != OTDOC_KIND_OFF);
      `OTDOC_CHK("oscBufDrive", on, oscBufDrive)
      `OTDOC_CHK("oscBufKind", k, oscBufKind)
      r = w[20] ? ratio_of(w[18:16]) : 4'h1;
      `OTDOC_CHK("oscRatio", r, oscRatio)
      `OTDOC_CHK("oscInPowerdown", w[19], oscInPowerdown)
      `OTDOC_CHK("vcoPathDivided", w[12], vcoPathDivided)
      r = w[12] ? ratio_of(w[10:8]) : 4'h1;
      `OTDOC_CHK("vcoRatio", r, vcoRatio)
      `OTDOC_CHK("feedbackMuxOn", w[11], feedbackMuxOn)
   endtask

   // shift one word msb first, latch it, then compare all outputs
   task automatic send_word(input logic [31:0] w, input logic [5:0] sel);
      for (int i = 31; i >= 0; i--) begin
         @(posedge clk_sys);
         serData <= w[i];
         serClk <= 1'b0;
         chanDelaySel <= sel;
         @(posedge clk_sys);
         serClk <= 1'b1;
      end
      @(posedge clk_sys);
      serClk <= 1'b0;
      serLatchEn <= 1'b1;
      @(posedge clk_sys);
      serLatchEn <= 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1;
      case (w[4:0])
         `OTDOC_ADDR_GROUP_A: grpWord[0] = w;
         `OTDOC_ADDR_GROUP_B: grpWord[1] = w;
         `OTDOC_ADDR_GROUP_C: grpWord[2] = w;
         `OTDOC_ADDR_OSC_CTRL: oscWord = w;
         default: ;
      endcase
      check_all();
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // timeout guard
   always @(posedge clk_sys) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 20000) begin
         nMismatch++;
         summarize();
      end
   end

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      serClk = 1'b0;
      serData = 1'b0;
      serLatchEn = 1'b0;
      chanDelaySel = 6'h00;
      grpWord = '{32'h0, 32'h0, 32'h0};
      oscWord = 32'h0;
      lfsrState = 32'h10;
      addrTab = '{5'h06, 5'h07, 5'h08, 5'h0a, 5'h00, 5'h09, 5'h0b, 5'h1f};
      nMismatch = 0;
      checksDone = 0;
      cycleCount = 0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      check_all();
      // every type code, delay codes up to 31 for clamping
      for (int c = 0; c < 16; c++) begin
         send_word({4'h0, 4'(15 - c), 4'(c), 4'(c), 5'(31 - 2 * c), 1'b0,
                    5'(2 * c), 5'(6 + c % 3)}, 6'(c * 5));
      end
      // every divider code on both paths of both dividers
      // host-owned bits swept
      for (int c = 0; c < 16; c++) begin
         send_word({4'h0, 4'(c), 1'b0, c[2], 1'b0, c[0], c[3], 3'(c >> 1),
                    3'h0, c[3], c[1], 3'(7 - c), 3'h0, 5'h0a}, 6'(c * 3));
      end
      // random words, unmapped addresses among them
      for (int n = 0; n < 60; n++) begin
         lfsrState = lfsr_next(lfsrState);
         send_word({lfsrState[31:5], addrTab[lfsrState[2:0]]},
                   lfsrState[16:11]);
      end
      // reset in mid-run clears all stored words
      @(posedge clk_sys);
      reset <= 1'b1;
      chanDelaySel <= 6'h00;
      @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      grpWord = '{32'h0, 32'h0, 32'h0};
      oscWord = 32'h0;
      check_all();
      summarize();
   end
endmodule
